// ==== bsf_pkg.sv ====
// Constants, register map and state types of the ballast sequencer
package bsf_pkg;
  localparam int unsigned CLK_MHZ = 125;

  function automatic int unsigned ns_up(input int unsigned ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction : ns_up

  function automatic int unsigned ns_dn(input int unsigned ns);
    return (ns * CLK_MHZ) / 1000;
  endfunction : ns_dn

  localparam int unsigned SOFT_MS      = 10;
  localparam int unsigned SOFT_CYC     = SOFT_MS * 1000 * CLK_MHZ;
  localparam int unsigned PH_STEP_MS   = 17;
  localparam int unsigned PH_STEP_CYC  = PH_STEP_MS * 1000 * CLK_MHZ;
  localparam int unsigned PH_MAX_MS    = 2000;
  localparam int unsigned PH_MAX_CYC   = PH_MAX_MS * 1000 * CLK_MHZ;
  localparam int unsigned SWEEP_MS     = 40;
  localparam int unsigned SLEW_CYC     = SWEEP_MS * 1000 * CLK_MHZ / 256;
  localparam int unsigned IGN_MS       = 235;
  localparam int unsigned IGN_CYC      = IGN_MS * 1000 * CLK_MHZ;
  localparam int unsigned PRERUN_MS    = 250;
  localparam int unsigned PRERUN_CYC   = PRERUN_MS * 1000 * CLK_MHZ;
  localparam int unsigned EVAL_MS      = 4;
  localparam int unsigned EVAL_CYC     = EVAL_MS * 1000 * CLK_MHZ;
  localparam int unsigned QUAL_MS      = 500;
  localparam int unsigned QUAL_TICKS   = QUAL_MS / EVAL_MS;
  localparam int unsigned PEAK_US      = 610;
  localparam int unsigned PEAK_CYC     = PEAK_US * CLK_MHZ;
  localparam int unsigned CAP2_TICK_US = 40;
  localparam int unsigned CAP2_TICK_CYC = CAP2_TICK_US * CLK_MHZ;
  localparam int unsigned CAP2_TICKS   = (PEAK_US + CAP2_TICK_US - 1) / CAP2_TICK_US;
  localparam int unsigned UV_US        = 80;
  localparam int unsigned UV_CYC       = UV_US * CLK_MHZ;
  localparam int unsigned PFC_STEP_US  = 400;
  localparam int unsigned PFC_STEP_CYC = PFC_STEP_US * CLK_MHZ;
  localparam int unsigned PFC_OFF_US   = 40;
  localparam int unsigned PFC_OFF_CYC  = PFC_OFF_US * CLK_MHZ;
  localparam int unsigned TON_INIT_CYC = ns_up(1000);
  localparam int unsigned TON_INC_CYC  = ns_up(1000);
  localparam int unsigned TON_MAX_CYC  = ns_dn(23000);
  localparam int unsigned TON_BCM_CYC  = ns_up(2300);
  localparam int unsigned TON_MIN_CYC  = ns_up(500);
  localparam int unsigned BLANK_CYC    = ns_up(500);
  localparam int unsigned DEAD_CYC     = ns_up(1800);
  localparam int unsigned START_KHZ    = 125;
  localparam int unsigned START_HALF   = CLK_MHZ * 1000 / (2 * START_KHZ);
  localparam int unsigned NOTCH_DLY    = 12;

  localparam logic [31:0] REG_PH_STEPS = 32'h0000_0000;
  localparam logic [31:0] REG_PH_HALF  = 32'h0000_0004;
  localparam logic [31:0] REG_RUN_HALF = 32'h0000_0008;
  localparam logic [31:0] REG_STATUS   = 32'h0000_000C;
  localparam logic [6:0]  PH_STEPS_RST = 7'h3B;
  localparam logic [15:0] PH_HALF_RST  = 16'h01A0;
  localparam logic [15:0] RUN_HALF_RST = 16'h04E2;
  localparam int unsigned ST_FLT_LSB   = 4;
  localparam int unsigned ST_BCM       = 10;
  localparam int unsigned ST_POV       = 11;
  localparam int unsigned ST_PG        = 12;
  localparam int unsigned ST_FC_LSB    = 16;

  localparam int unsigned F_PEAK  = 0;
  localparam int unsigned F_ASYM  = 1;
  localparam int unsigned F_CAP1  = 2;
  localparam int unsigned F_CAP2  = 3;
  localparam int unsigned F_OVCUR = 4;
  localparam int unsigned F_NOIGN = 5;

  typedef enum logic [3:0] {
    M_OFF = 4'b0000, M_FIL = 4'b0001, M_WAIT = 4'b0010, M_PDN = 4'b0011,
    M_OVH = 4'b0100, M_SOFT = 4'b0101, M_PH = 4'b0110, M_IGN = 4'b0111,
    M_PRE = 4'b1000, M_RUN = 4'b1001, M_FLT = 4'b1010, M_UVO = 4'b1011
  } bsf_mode_type;

  typedef enum logic [1:0] {P_IDLE = 2'b00, P_ON = 2'b01, P_OFF = 2'b10} bsf_pfc_type;

  typedef struct packed {
    logic vcc_ok, vcc_start, fil_above, fil_below, lvs_ok;
    logic bus_open, bus_over, bus_rec, bus_under, pfc_shunt, zcd;
    logic cur_low, cur_high, lamp_peak, lamp_dc, lamp_asym, cap_mild, cap_severe, bvs;
  } bsf_in_type;

  typedef struct packed {
    bsf_in_type sy1, sy2;
    logic zd;
    bsf_mode_type mode;
    logic [27:0] tm;
    logic [15:0] half, hc, sd;
    logic [14:0] sl;
    logic ph, hs, ls, cap1, cap2, fs;
    logic [5:0] flt;
    logic [7:0] fc;
    logic [18:0] tk4;
    logic [16:0] pk;
    logic [4:0] c2;
    logic [12:0] tk40;
    logic [13:0] uv;
    bsf_pfc_type pst;
    logic [15:0] pt, ton, xoff, rt;
    logic bcm, nz, zl, pov, pg;
    logic [6:0] blank;
    logic [8:0] ac;
    logic [7:0] as;
    logic [NOTCH_DLY-1:0][7:0] dl;
    logic signed [19:0] ig;
    logic [6:0] steps;
    logic [15:0] phh, runh;
    logic [31:0] ha, rd;
    logic wen, hrdy, hrsp;
  } bsf_st_type;
endpackage : bsf_pkg

// ==== bsf_ctrl.sv ====
// Ballast start-up sequencer, PFC timing and fault monitor behind an AHB-Lite slave
`timescale 1ns/1ps

module bsf_ctrl #(
  parameter int unsigned SOFT_CYC      = bsf_pkg::SOFT_CYC,
  parameter int unsigned PH_STEP_CYC   = bsf_pkg::PH_STEP_CYC,
  parameter int unsigned PH_MAX_CYC    = bsf_pkg::PH_MAX_CYC,
  parameter int unsigned SLEW_CYC      = bsf_pkg::SLEW_CYC,
  parameter int unsigned IGN_CYC       = bsf_pkg::IGN_CYC,
  parameter int unsigned PRERUN_CYC    = bsf_pkg::PRERUN_CYC,
  parameter int unsigned EVAL_CYC      = bsf_pkg::EVAL_CYC,
  parameter int unsigned PEAK_CYC      = bsf_pkg::PEAK_CYC,
  parameter int unsigned CAP2_TICK_CYC = bsf_pkg::CAP2_TICK_CYC,
  parameter int unsigned UV_CYC        = bsf_pkg::UV_CYC,
  parameter int unsigned PFC_STEP_CYC  = bsf_pkg::PFC_STEP_CYC,
  parameter int unsigned PFC_OFF_CYC   = bsf_pkg::PFC_OFF_CYC
) (
  // Clock, reset, enable
  input  logic        ref_clk,
  input  logic        reset_n,
  input  logic        ce,
  // AHB-Lite slave
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic [31:0] hrdata,
  output logic        hresp,
  // Supply and filament comparators
  input  logic        vcc_uvlo_ok,
  input  logic        vcc_start_ok,
  input  logic        filament_sense_above,
  input  logic        filament_sense_below,
  input  logic        lamp_voltage_sense_ok,
  // Bus voltage comparators and converter bitstream
  input  logic        bus_open_loop,
  input  logic        bus_over,
  input  logic        bus_recover,
  input  logic        bus_under,
  input  logic        bus_voltage_sense,
  // PFC and inverter current comparators
  input  logic        pfc_shunt_trip,
  input  logic        zero_current_input,
  input  logic        inv_cur_low,
  input  logic        inv_cur_high,
  // Lamp and capacitive mode comparators
  input  logic        lamp_peak,
  input  logic        lamp_dc,
  input  logic        lamp_asym,
  input  logic        cap_mild_cmp,
  input  logic        cap_severe_cmp,
  // Drives and status
  output logic        inv_hs_gate,
  output logic        inv_ls_gate,
  output logic        pfc_gate,
  output logic [3:0]  lamp_mode,
  output logic        fault_mode
);
  localparam int unsigned ADC_SUB = (PFC_STEP_CYC / 256 > 0) ? PFC_STEP_CYC / 256 : 1;

  bsf_pkg::bsf_st_type q;
  bsf_pkg::bsf_st_type n;
  bsf_pkg::bsf_in_type s;

  function automatic logic [15:0] absd(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? b - a : a - b;
  endfunction : absd

  // Move c toward t by at most d
  function automatic logic [15:0] slew(input logic [15:0] c, input logic [15:0] t,
                                       input logic [15:0] d);
    logic [15:0] r;
    r = absd(c, t);
    if (r > d) r = d;
    return (c < t) ? c + r : c - r;
  endfunction : slew

  // Saturating up/down integrator
  function automatic logic [16:0] updn(input logic [16:0] c, input logic up);
    if (up) return (&c) ? c : c + 17'h0_0001;
    return (c == '0) ? c : c - 17'h0_0001;
  endfunction : updn

  assign s = q.sy2;

  always_comb begin
    logic act, tk4, tk40, slt, rtt, zok, zl, go;
    logic signed [8:0] e;
    logic signed [8:0] y;
    logic signed [20:0] tp;
    int unsigned phd;
    act = 1'b0;
    tk4 = 1'b0;
    tk40 = 1'b0;
    slt = 1'b0;
    rtt = 1'b0;
    zok = 1'b0;
    zl = 1'b0;
    go = 1'b0;
    e = '0;
    y = '0;
    tp = '0;
    phd = 0;
    n = q;
    n.sy1 = {vcc_uvlo_ok, vcc_start_ok, filament_sense_above, filament_sense_below,
             lamp_voltage_sense_ok, bus_open_loop, bus_over, bus_recover, bus_under,
             pfc_shunt_trip, zero_current_input, inv_cur_low, inv_cur_high, lamp_peak,
             lamp_dc, lamp_asym, cap_mild_cmp, cap_severe_cmp, bus_voltage_sense};
    n.sy2 = q.sy1;
    n.zd = s.zcd;
    act = q.mode inside {bsf_pkg::M_SOFT, bsf_pkg::M_PH, bsf_pkg::M_IGN,
                         bsf_pkg::M_PRE, bsf_pkg::M_RUN};

    // Free-running ticks
    tk4 = (32'(q.tk4) == EVAL_CYC - 1);
    n.tk4 = tk4 ? '0 : q.tk4 + 19'h1;
    tk40 = (32'(q.tk40) == CAP2_TICK_CYC - 1);
    n.tk40 = tk40 ? '0 : q.tk40 + 13'h1;
    slt = (32'(q.sl) == SLEW_CYC - 1);
    n.sl = slt ? '0 : q.sl + 15'h1;

    // Half-bridge with dead time on both edges
    if (act) begin
      if (q.hc >= q.half - 16'h0001) begin
        n.hc = '0;
        n.ph = ~q.ph;
      end else begin
        n.hc = q.hc + 16'h0001;
      end
    end else begin
      n.hc = '0;
      n.ph = 1'b0;
    end
    n.hs = act & n.ph & (32'(n.hc) >= bsf_pkg::DEAD_CYC);
    n.ls = act & ~n.ph & (32'(n.hc) >= bsf_pkg::DEAD_CYC);
    if (n.ls && !q.ls) n.cap1 = s.cap_mild;
    if (n.hs && !q.hs) n.cap2 = s.cap_severe;

    // Operating mode sequence
    phd = 32'(q.steps) * PH_STEP_CYC;
    if (phd > PH_MAX_CYC) phd = PH_MAX_CYC;
    case (q.mode)
      bsf_pkg::M_OFF: begin
        n.fs = 1'b0;
        if (s.vcc_ok) n.mode = bsf_pkg::M_FIL;
      end
      bsf_pkg::M_FIL, bsf_pkg::M_WAIT: begin
        // Threshold drops to the lower level once an open filament was seen
        if (s.fil_above) n.fs = 1'b1;
        if ((q.fs ? !s.fil_below : s.fil_above) || !s.lvs_ok) begin
          n.mode = bsf_pkg::M_FIL;
        end else if (q.mode == bsf_pkg::M_FIL) begin
          n.mode = bsf_pkg::M_WAIT;
          n.fs = 1'b0;
        end else if (s.vcc_start) begin
          if (s.bus_open) n.mode = bsf_pkg::M_PDN;
          else if (s.bus_over) n.mode = bsf_pkg::M_OVH;
          else begin
            n.mode = bsf_pkg::M_SOFT;
            n.half = 16'(bsf_pkg::START_HALF);
            n.sd = (absd(q.phh, 16'(bsf_pkg::START_HALF)) >> 6) + 16'h0001;
          end
        end
      end
      bsf_pkg::M_PDN: if (!s.bus_open) n.mode = bsf_pkg::M_WAIT;
      bsf_pkg::M_SOFT: begin
        if (slt) n.half = slew(q.half, q.phh, q.sd);
        if (32'(q.tm) >= SOFT_CYC - 1) n.mode = bsf_pkg::M_PH;
      end
      bsf_pkg::M_PH: begin
        n.half = q.phh;
        if (32'(q.tm) >= phd) begin
          n.mode = bsf_pkg::M_IGN;
          n.sd = (absd(q.runh, q.phh) >> 8) + 16'h0001;
        end
      end
      bsf_pkg::M_IGN: begin
        if (slt) begin
          if (s.cur_low) n.half = slew(q.half, q.phh, q.sd << 2);
          else n.half = slew(q.half, q.runh, q.sd);
        end
        if (q.half == q.runh) n.mode = bsf_pkg::M_PRE;
        else if (32'(q.tm) >= IGN_CYC - 1) begin
          n.mode = bsf_pkg::M_FLT;
          n.flt[bsf_pkg::F_NOIGN] = 1'b1;
        end
      end
      bsf_pkg::M_PRE: if (32'(q.tm) >= PRERUN_CYC - 1) n.mode = bsf_pkg::M_RUN;
      bsf_pkg::M_RUN: n.half = q.runh;
      bsf_pkg::M_FLT: begin
        if (s.fil_above) n.fs = 1'b1;
        if (q.fs && s.fil_below) begin
          n.mode = bsf_pkg::M_FIL;
          n.flt = '0;
          n.fs = 1'b0;
        end
      end
      bsf_pkg::M_OVH, bsf_pkg::M_UVO: n.mode = q.mode;
      default: n.mode = bsf_pkg::M_OFF;
    endcase

    // Run-mode monitors, idle elsewhere; the severe capacitive counter also runs in preheat
    n.fc = (q.mode == bsf_pkg::M_RUN) ? q.fc : '0;
    n.pk = (q.mode == bsf_pkg::M_RUN) ? q.pk : '0;
    n.uv = (q.mode == bsf_pkg::M_RUN && s.bus_under) ? q.uv + 14'h1 : '0;
    n.c2 = (q.mode inside {bsf_pkg::M_PH, bsf_pkg::M_RUN}) ? q.c2 : '0;
    if (q.mode == bsf_pkg::M_RUN) begin
      if (tk4) n.fc = 8'(updn({9'h0, q.fc}, s.lamp_asym | q.cap1));
      n.pk = updn(q.pk, s.lamp_peak | s.lamp_dc);
      if (32'(q.fc) >= bsf_pkg::QUAL_TICKS) begin
        n.mode = bsf_pkg::M_FLT;
        if (s.lamp_asym) n.flt[bsf_pkg::F_ASYM] = 1'b1;
        else n.flt[bsf_pkg::F_CAP1] = 1'b1;
      end
      if (32'(q.pk) > PEAK_CYC) begin
        n.mode = bsf_pkg::M_FLT;
        n.flt[bsf_pkg::F_PEAK] = 1'b1;
      end
      if (32'(q.uv) > UV_CYC) n.mode = bsf_pkg::M_UVO;
    end
    if (q.mode inside {bsf_pkg::M_PH, bsf_pkg::M_RUN}) begin
      if (tk40) n.c2 = 5'(updn({12'h000, q.c2}, q.cap2));
      if (32'(q.c2) >= bsf_pkg::CAP2_TICKS) begin
        n.mode = bsf_pkg::M_FLT;
        n.flt[bsf_pkg::F_CAP2] = 1'b1;
      end
    end
    if (act && s.bus_open) n.mode = bsf_pkg::M_PDN;
    if (act && s.cur_high) begin
      n.mode = bsf_pkg::M_FLT;
      n.flt[bsf_pkg::F_OVCUR] = 1'b1;
    end
    if (n.mode == bsf_pkg::M_FLT && q.mode != bsf_pkg::M_FLT) n.fs = 1'b0;
    if (!s.vcc_ok) begin
      n.mode = bsf_pkg::M_OFF;
      n.flt = '0;
    end
    n.tm = (n.mode != q.mode) ? '0 : q.tm + 28'h1;

    // PFC overvoltage latch with recovery hysteresis
    if (s.bus_over) n.pov = 1'b1;
    else if (s.bus_rec) n.pov = 1'b0;

    // Bus error converter and regulator
    rtt = (32'(q.rt) == PFC_STEP_CYC - 1);
    n.rt = rtt ? '0 : q.rt + 16'h0001;
    n.as = (32'(q.as) == ADC_SUB - 1) ? '0 : q.as + 8'h01;
    if (32'(q.as) == ADC_SUB - 1 && q.ac != 9'h0FF) n.ac = q.ac + {8'h00, s.bvs};
    if (rtt) begin
      n.ac = '0;
      e = 9'(signed'({1'b0, q.ac}) - 9'sh080);
      y = 9'((e + signed'({q.dl[bsf_pkg::NOTCH_DLY-1][7], q.dl[bsf_pkg::NOTCH_DLY-1]})) >>> 1);
      n.dl = {q.dl[bsf_pkg::NOTCH_DLY-2:0], e[7:0]};
      n.ig = q.ig - 20'(y);
      if (n.ig < 0) n.ig = '0;
      if (n.ig > 20'sd2875) n.ig = 20'sd2875;
      tp = 21'(n.ig) - (21'(y) <<< 3);
    end

    zok = (q.sy2.zcd & ~q.zd) & (q.blank == '0);
    n.blank = (q.blank == '0) ? '0 : q.blank - 7'h01;
    zl = q.zl | zok;
    if (!act) begin
      n.pst = bsf_pkg::P_IDLE;
      n.ton = 16'(bsf_pkg::TON_INIT_CYC);
      n.bcm = 1'b0;
      n.nz = 1'b0;
      n.zl = 1'b0;
      n.xoff = '0;
      n.ig = '0;
    end else begin
      if (rtt && !q.bcm && 32'(q.ton) < bsf_pkg::TON_MAX_CYC) begin
        n.ton = q.ton + 16'(bsf_pkg::TON_INC_CYC);
        if (32'(n.ton) > bsf_pkg::TON_MAX_CYC) n.ton = 16'(bsf_pkg::TON_MAX_CYC);
      end
      if (rtt && q.bcm) begin
        n.ton = 16'(bsf_pkg::TON_MAX_CYC);
        if (tp < signed'(21'(bsf_pkg::TON_MAX_CYC))) n.ton = 16'(tp);
        if (tp < signed'(21'(bsf_pkg::TON_MIN_CYC))) n.ton = 16'(bsf_pkg::TON_MIN_CYC);
        n.xoff = (32'(n.ton) < bsf_pkg::TON_BCM_CYC) ?
                 (16'(bsf_pkg::TON_BCM_CYC) - n.ton) << 3 : '0;
      end
      case (q.pst)
        bsf_pkg::P_IDLE: begin
          n.pst = bsf_pkg::P_ON;
          n.pt = '0;
          n.ig = 20'(q.ton);
        end
        bsf_pkg::P_ON: begin
          n.pt = q.pt + 16'h0001;
          if (s.pfc_shunt || q.pt >= q.ton - 16'h0001) begin
            n.pst = bsf_pkg::P_OFF;
            n.pt = '0;
            n.nz = s.pfc_shunt;
            n.zl = 1'b0;
            n.blank = 7'(bsf_pkg::BLANK_CYC);
          end
        end
        bsf_pkg::P_OFF: begin
          n.pt = q.pt + 16'h0001;
          n.zl = zl;
          if (zok && !q.bcm) begin
            n.bcm = 1'b1;
            n.ig = 20'(q.ton);
          end
          if (q.nz || q.bcm) go = zl && (q.pt >= (q.bcm ? q.xoff : 16'h0000));
          else go = 32'(q.pt) >= PFC_OFF_CYC - 1;
          if (go) begin
            n.pst = bsf_pkg::P_ON;
            n.pt = '0;
            n.nz = 1'b0;
            n.zl = 1'b0;
            n.blank = 7'(bsf_pkg::BLANK_CYC);
          end
        end
        default: n.pst = bsf_pkg::P_IDLE;
      endcase
    end
    // Park the PFC: with the gate off no zero-current edge would come to restart it
    if (n.pov) n.pst = bsf_pkg::P_IDLE;
    n.pg = (n.pst == bsf_pkg::P_ON) & ~n.pov;

    // Register slave: zero wait states, always OKAY
    n.hrdy = 1'b1;
    n.hrsp = 1'b0;
    if (q.wen) begin
      case (q.ha)
        bsf_pkg::REG_PH_STEPS: n.steps = hwdata[6:0];
        bsf_pkg::REG_PH_HALF:  n.phh = hwdata[15:0];
        bsf_pkg::REG_RUN_HALF: n.runh = hwdata[15:0];
        default: n.wen = 1'b0;
      endcase
    end
    n.wen = 1'b0;
    if (hsel && htrans[1] && hready && hsize == 3'b010) begin
      n.wen = hwrite;
      n.ha = {haddr[31:2], 2'b00};
      n.rd = '0;
      if (!hwrite) begin
        case ({haddr[31:2], 2'b00})
          bsf_pkg::REG_PH_STEPS: n.rd[6:0] = q.steps;
          bsf_pkg::REG_PH_HALF:  n.rd[15:0] = q.phh;
          bsf_pkg::REG_RUN_HALF: n.rd[15:0] = q.runh;
          bsf_pkg::REG_STATUS: begin
            n.rd[3:0] = q.mode;
            n.rd[bsf_pkg::ST_FLT_LSB +: 6] = q.flt;
            n.rd[bsf_pkg::ST_BCM] = q.bcm;
            n.rd[bsf_pkg::ST_POV] = q.pov;
            n.rd[bsf_pkg::ST_PG] = q.pg;
            n.rd[bsf_pkg::ST_FC_LSB +: 8] = q.fc;
          end
          default: n.rd = '0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.hrdy <= 1'b1;
      q.steps <= bsf_pkg::PH_STEPS_RST;
      q.phh <= bsf_pkg::PH_HALF_RST;
      q.runh <= bsf_pkg::RUN_HALF_RST;
    end else if (ce) begin
      q <= n;
    end
  end

  assign hreadyout   = q.hrdy;
  assign hrdata      = q.rd;
  assign hresp       = q.hrsp;
  assign inv_hs_gate = q.hs;
  assign inv_ls_gate = q.ls;
  assign pfc_gate    = q.pg;
  assign lamp_mode   = q.mode;
  assign fault_mode  = (q.mode == bsf_pkg::M_FLT);
endmodule : bsf_ctrl

// ==== bsf_ctrl_monitor.sv ====
// Assertion checker for the ballast sequencer
`timescale 1ns/1ps
module bsf_ctrl_monitor #(
  parameter int unsigned IGN_CYC    = 3000,
  parameter int unsigned PRERUN_CYC = 300
) (
  // Clock, reset, comparators
  input logic       ref_clk,
  input logic       reset_n,
  input logic       ce,
  input logic       vcc_uvlo_ok,
  input logic       bus_over,
  input logic       pfc_shunt_trip,
  input logic       inv_cur_high,
  // Drives and mode
  input logic       inv_hs_gate,
  input logic       inv_ls_gate,
  input logic       pfc_gate,
  input logic [3:0] lamp_mode,
  input logic       fault_mode
);
  logic [3:0]  mode_q;
  logic [15:0] dwell_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n || !ce);
  // Cycles spent in the current mode
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q  <= 4'h0;
      dwell_q <= 16'h0000;
    end else begin
      mode_q  <= lamp_mode;
      dwell_q <= (lamp_mode != mode_q) ? 16'h0000 : dwell_q + 16'h0001;
    end
  end
  a_uvlo_idle: assert property (!vcc_uvlo_ok [*5] |-> lamp_mode == 4'h0 && !fault_mode)
    else $error("Mode active below lockout");
  a_hold_nodrive: assert property (lamp_mode inside {4'h3, 4'h4} && mode_q == lamp_mode
    |-> !inv_hs_gate && !inv_ls_gate) else $error("Drive in hold mode");
  a_dead_time: assert property ($fell(inv_hs_gate) |=> !inv_ls_gate [*8])
    else $error("Gate overlap");
  a_shunt_cut: assert property ($rose(pfc_shunt_trip) |-> ##[1:4] !pfc_gate)
    else $error("On-time not cut");
  a_ovcur_latch: assert property (inv_cur_high [*3] && lamp_mode inside {[4'h5:4'h9]}
    |-> ##[1:4] fault_mode) else $error("Overcurrent not latched");
  a_fault_nodrive: assert property (fault_mode && $past(fault_mode)
    |-> !inv_hs_gate && !inv_ls_gate && !pfc_gate) else $error("Drive in fault");
  a_ov_pfc_off: assert property (bus_over [*5] |-> !pfc_gate)
    else $error("PFC drive in overvoltage");
  a_ign_window: assert property (lamp_mode == 4'h7 && mode_q == 4'h7 |-> dwell_q <= IGN_CYC + 2)
    else $error("Ignition window overrun");
  a_prerun_len: assert property (lamp_mode == 4'h9 && mode_q == 4'h8
    |-> dwell_q + 2 >= PRERUN_CYC && dwell_q <= PRERUN_CYC + 1) else $error("Pre-run length");
  c_fault: cover property ($rose(fault_mode));
  c_run: cover property (lamp_mode == 4'h9 && mode_q == 4'h8);
  c_pfc: cover property ($rose(pfc_gate));
endmodule : bsf_ctrl_monitor

bind bsf_ctrl bsf_ctrl_monitor #(.IGN_CYC(IGN_CYC), .PRERUN_CYC(PRERUN_CYC)) bsf_ctrl_monitor_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .vcc_uvlo_ok(vcc_uvlo_ok), .bus_over(bus_over),
  .pfc_shunt_trip(pfc_shunt_trip), .inv_cur_high(inv_cur_high), .inv_hs_gate(inv_hs_gate),
  .inv_ls_gate(inv_ls_gate), .pfc_gate(pfc_gate), .lamp_mode(lamp_mode), .fault_mode(fault_mode));

// ==== bsf_stage_model.sv ====
// Behavioural PFC stage seen through its comparators
`timescale 1ns/1ps
module bsf_stage_model #(
  parameter int unsigned ILIM  = 100,
  parameter int unsigned DEMAG = 80
) (
  // Clock and gate
  input  logic ref_clk,
  input  logic pfc_gate,
  // Comparators
  output logic pfc_shunt_trip,
  output logic zero_current_input,
  output logic bus_voltage_sense
);
  logic [15:0] on_q  = 16'h0000;
  logic [15:0] off_q = 16'h0000;
  logic        bit_q = 1'h0;
  // Current ramps while on, demagnetises after
  always_ff @(posedge ref_clk) begin
    on_q  <= pfc_gate ? on_q + 16'h0001 : 16'h0000;
    off_q <= pfc_gate ? 16'h0000 : off_q + 16'h0001;
    bit_q <= ~bit_q;
  end
  assign pfc_shunt_trip     = pfc_gate && on_q >= ILIM;
  assign zero_current_input = !pfc_gate && off_q >= DEMAG;
  // Bus at reference: half-density bitstream
  assign bus_voltage_sense  = bit_q;
endmodule : bsf_stage_model

// ==== tb.sv ====
// Self-checking bench for the ballast sequencer
`timescale 1ns/1ps
module tb;
  localparam int unsigned T_SOFT = 200, T_STEP = 50, T_SLEW = 4, T_IGN = 3000, T_PRE = 300, T_EVAL = 10;
  localparam int unsigned T_PEAK = 100, T_CAP2 = 10;
  logic                ref_clk, reset_n, hready, hwrite, hresp, ce, hsel;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [31:0]         haddr, hwdata, hrdata, rd;
  logic                hs, ls, pg, fault_mode, zcd, shunt, bvs;
  logic [3:0]          lamp_mode;
  bsf_pkg::bsf_in_type cin;
  int                  n_errors, n_tests;

  bsf_ctrl #(.SOFT_CYC(T_SOFT), .PH_STEP_CYC(T_STEP), .SLEW_CYC(T_SLEW), .IGN_CYC(T_IGN), .PRERUN_CYC(T_PRE),
    .EVAL_CYC(T_EVAL), .PEAK_CYC(T_PEAK), .CAP2_TICK_CYC(T_CAP2)) bsf_ctrl_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .vcc_uvlo_ok(cin.vcc_ok),
    .vcc_start_ok(cin.vcc_start), .filament_sense_above(cin.fil_above),
    .filament_sense_below(cin.fil_below), .lamp_voltage_sense_ok(cin.lvs_ok),
    .bus_open_loop(cin.bus_open), .bus_over(cin.bus_over), .bus_recover(cin.bus_rec),
    .bus_under(cin.bus_under), .bus_voltage_sense(bvs), .pfc_shunt_trip(shunt),
    .zero_current_input(zcd), .inv_cur_low(cin.cur_low), .inv_cur_high(cin.cur_high),
    .lamp_peak(cin.lamp_peak), .lamp_dc(cin.lamp_dc), .lamp_asym(cin.lamp_asym),
    .cap_mild_cmp(cin.cap_mild), .cap_severe_cmp(cin.cap_severe), .inv_hs_gate(hs),
    .inv_ls_gate(ls), .pfc_gate(pg), .lamp_mode(lamp_mode), .fault_mode(fault_mode));
  bsf_stage_model bsf_stage_model_inst (.ref_clk(ref_clk), .pfc_gate(pg), .pfc_shunt_trip(shunt),
    .zero_current_input(zcd), .bus_voltage_sense(bvs));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask : bus

  task automatic wm(input logic [3:0] m, input int lim);
    for (int i = 0; i < lim && lamp_mode !== m; i++) @(posedge ref_clk);
    chk("lamp_mode", 32'(m), 32'(lamp_mode));
  endtask : wm

  task automatic test_done();
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic t_start();
    bus(1'h1, bsf_pkg::REG_PH_STEPS, 32'h0000_0002);
    bus(1'h0, bsf_pkg::REG_PH_STEPS, 32'h0000_0000);
    chk("ph_steps", 32'h0000_0002, rd);
    bus(1'h0, 32'h0000_0010, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    chk("hresp", 32'h0000_0000, 32'(hresp));
    hsize <= 3'h0;
    bus(1'h1, bsf_pkg::REG_PH_STEPS, 32'h0000_0005);
    hsize <= 3'h2;
    hsel  <= 1'h0;
    bus(1'h1, bsf_pkg::REG_PH_STEPS, 32'h0000_0007);
    hsel <= 1'h1;
    bus(1'h0, bsf_pkg::REG_PH_STEPS, 32'h0000_0000);
    chk("ignored_wr", 32'h0000_0002, rd);
    cin.fil_above <= 1'h1;
    cin.fil_below <= 1'h0;
    cin.vcc_ok    <= 1'h1;
    cin.vcc_start <= 1'h1;
    wm(4'h1, 20);
    repeat (200) @(posedge ref_clk);
    chk("open_filament", 32'h0000_0001, 32'(lamp_mode));
    cin.fil_above <= 1'h0;
    cin.fil_below <= 1'h1;
    cin.lvs_ok    <= 1'h0;
    repeat (20) @(posedge ref_clk);
    chk("hs_filament", 32'h0000_0001, 32'(lamp_mode));
    cin.lvs_ok <= 1'h1;
    wm(4'h5, 20);
    wm(4'h6, 300);
    ce <= 1'h0;
    repeat (300) @(posedge ref_clk);
    chk("ce_freeze", 32'h0000_0006, 32'(lamp_mode));
    ce <= 1'h1;
    wm(4'h7, 200);
    wm(4'h8, 1300);
    wm(4'h9, 400);
    for (int i = 0; i < 3000 && hs !== 1'h1; i++) @(posedge ref_clk);
    chk("hs_ls", 32'h0000_0002, 32'({hs, ls}));
    cin.bus_over <= 1'h1;
    cin.bus_rec  <= 1'h0;
    repeat (10) @(posedge ref_clk);
    cin.bus_over <= 1'h0;
    repeat (10) @(posedge ref_clk);
    bus(1'h0, bsf_pkg::REG_STATUS, 32'h0000_0000);
    chk("pov_hold", 32'h0000_0800, rd & 32'h0000_1800);
    cin.bus_rec <= 1'h1;
    for (int i = 0; i < 400 && pg !== 1'h1; i++) @(posedge ref_clk);
    chk("pfc_resume", 32'h0000_0001, 32'(pg));
    cin.bus_under <= 1'h1;
    wm(4'hb, 10100);
    repeat (2) @(posedge ref_clk);
    chk("uv_off", 32'h0000_0000, 32'({fault_mode, hs, ls, pg}));
    cin.bus_under <= 1'h0;
  endtask : t_start

  task automatic t_bus();
    cin.vcc_ok   <= 1'h0;
    cin.bus_open <= 1'h1;
    wm(4'h0, 10);
    cin.vcc_ok <= 1'h1;
    wm(4'h3, 20);
    cin.bus_open <= 1'h0;
    wm(4'h5, 20);
    cin.vcc_ok   <= 1'h0;
    cin.bus_over <= 1'h1;
    cin.bus_rec  <= 1'h0;
    repeat (10) @(posedge ref_clk);
    cin.vcc_ok <= 1'h1;
    wm(4'h4, 20);
    cin.vcc_ok   <= 1'h0;
    cin.bus_over <= 1'h0;
    cin.bus_rec  <= 1'h1;
    repeat (10) @(posedge ref_clk);
    cin.vcc_ok <= 1'h1;
  endtask : t_bus

  task automatic t_faults();
    for (int f = 0; f < 7; f++) begin
      wm((f == bsf_pkg::F_NOIGN) ? 4'h7 : 4'h9, 2200);
      case (f)
        bsf_pkg::F_PEAK:  cin.lamp_peak  <= 1'h1;
        bsf_pkg::F_ASYM:  cin.lamp_asym  <= 1'h1;
        bsf_pkg::F_CAP1:  cin.cap_mild   <= 1'h1;
        bsf_pkg::F_CAP2:  cin.cap_severe <= 1'h1;
        bsf_pkg::F_OVCUR: cin.cur_high   <= 1'h1;
        bsf_pkg::F_NOIGN: cin.cur_low    <= 1'h1;
        default:          cin.lamp_dc    <= 1'h1;
      endcase
      wm(4'ha, 4000);
      // Release every lamp and current comparator
      cin[7:1] <= 7'h00;
      bus(1'h0, bsf_pkg::REG_STATUS, 32'h0000_0000);
      chk("fault_bits", 32'h0000_0001 << ((f == 6) ? 0 : f), 32'(rd[9:4]));
      cin.fil_above <= 1'h1;
      cin.fil_below <= 1'h0;
      repeat (10) @(posedge ref_clk);
      chk("fault_held", 32'h0000_000A, 32'(lamp_mode));
      chk("fault_out", 32'h0000_0008, 32'({fault_mode, hs, ls, pg}));
      cin.fil_above <= 1'h0;
      cin.fil_below <= 1'h1;
      wm(4'h1, 10);
    end
  endtask : t_faults

  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    reset_n     = 1'h0;
    htrans      = 2'h0;
    haddr       = 32'h0000_0000;
    hwrite      = 1'h0;
    hwdata      = 32'h0000_0000;
    ce          = 1'h1;
    hsel        = 1'h1;
    hsize       = 3'h2;
    cin         = '0;
    cin.bus_rec = 1'h1;
    cin.lvs_ok  = 1'h1;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'h1;
    t_start();
    t_bus();
    t_faults();
    test_done();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end
endmodule : tb
